// ===== src/cssc_fifo.v
// Synchronous FIFO with registered head word, valid and ready.
// Assumes one clock domain and a synchronous active-high reset.
`include "cssc_regs.vh"

module cssc_fifo #(
   parameter W = 32
) (
   input wire clock,
   input wire sys_rst,
   input wire flush,
   input wire in_valid,
   input wire [W-1:0] in_data,
   output reg in_ready,
   output reg out_valid,
   output reg [W-1:0] out_data,
   input wire out_ready
);

   // Storage array, pointers and fill level
   reg [W-1:0] mem [0:`CSSC_FIFO_DEPTH-1];
   reg [`CSSC_FIFO_AW-1:0] wr_ptr_r;
   reg [`CSSC_FIFO_AW-1:0] rd_ptr_r;
   reg [3:0] count_r;
   reg [3:0] count_nxt;
   reg [`CSSC_FIFO_AW-1:0] rd_ptr_nxt;
   wire do_wr;
   wire do_rd;

   // Pointer step with natural wrap
   function [`CSSC_FIFO_AW-1:0] ptr_inc;
      input [`CSSC_FIFO_AW-1:0] p;
      input en;
      begin
         ptr_inc = en ? p + 3'h1 : p;
      end
   endfunction

   // Handshakes on both sides
   assign do_wr = in_valid && in_ready && !flush;
   assign do_rd = out_valid && out_ready && !flush;

   // Next fill level and read pointer
   always @*
   begin
      rd_ptr_nxt = ptr_inc(rd_ptr_r, do_rd);
      count_nxt = count_r;
      if (do_wr && !do_rd)
      begin
         count_nxt = count_r + 4'h1;
      end
      else if (do_rd && !do_wr)
      begin
         count_nxt = count_r - 4'h1;
      end
   end

   // Storage write
   always @(posedge clock)
   begin
      if (do_wr)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Pointers, flags and head word; flush empties the queue
   always @(posedge clock)
   begin
      if (sys_rst || flush)
      begin
         wr_ptr_r <= 3'h0;
         rd_ptr_r <= 3'h0;
         count_r <= 4'h0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= {W{1'b0}};
         if (flush && !sys_rst)
         begin
            in_ready <= 1'b1;
         end
      end
      else
      begin
         wr_ptr_r <= ptr_inc(wr_ptr_r, do_wr);
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         in_ready <= (count_nxt != `CSSC_FIFO_DEPTH);
         out_valid <= (count_nxt != 4'h0);
         // Bypass a word written into the slot that becomes the head
         if (do_wr && (wr_ptr_r == rd_ptr_nxt))
         begin
            out_data <= in_data;
         end
         else
         begin
            out_data <= mem[rd_ptr_nxt];
         end
      end
   end

endmodule

// ===== src/cssc_regs.vh
// Constants shared by the security state controller and its FIFOs.
// Assumes a single 25 MHz clock and the engine datapath outside this block.
`ifndef CSSC_REGS_VH
`define CSSC_REGS_VH

// Data word width on every stream
`define CSSC_DW 32
// Words held by each FIFO, and pointer width
`define CSSC_FIFO_DEPTH 4'h8
`define CSSC_FIFO_AW 3
// Words of secret parameter storage per mode bank, and address width
`define CSSC_KEY_WORDS 8
`define CSSC_KEY_AW 3
// Number of known-answer checks run after every reset
`define CSSC_NUM_KAT 3'h4
// Top state codes
`define CSSC_ST_INIT 3'h0
`define CSSC_ST_KAT_GO 3'h1
`define CSSC_ST_KAT_WAIT 3'h2
`define CSSC_ST_READY 3'h3
`define CSSC_ST_SERVICE 3'h4
`define CSSC_ST_LOCKED 3'h5

`endif

// ===== src/cssc_top.v
// Security state controller of the crypto engine: self-test gate, mode
// tracking, split secret parameter banks, lock, and the data FIFOs.
// Assumes the cipher datapath sits outside, on the core_* ports.
//
// Functional notes
// - Approved mode only after self-tests pass
// - Non-approved request switches mode during service
// - Service end returns at once to approved
// - Separate secret parameter banks per mode
// - No service before init and tests pass
// - Any known-answer check failure locks device
// - Only reset unlocks; reset reruns all checks
// - Secret parameters are never readable outside
// - Reset zeroizes both key banks; key words left in the input FIFO memory are not cleared
// - No path around the cryptographic datapath
// - Data via FIFOs, control/status via registers
// - Keys by direct write or FIFO
// - Errors expose no key in outputs
`include "cssc_regs.vh"

module cssc_top (
   input wire clock,
   input wire sys_rst,
   // Input stream; din_key marks a secret parameter word
   input wire din_valid,
   input wire [31:0] din_data,
   input wire din_key,
   output wire din_ready,
   // Output stream
   output wire dout_valid,
   output wire [31:0] dout_data,
   input wire dout_ready,
   // Direct secret parameter write
   input wire key_wr_en,
   input wire key_wr_bank,
   input wire [2:0] key_wr_addr,
   input wire [31:0] key_wr_data,
   // Bank for secret parameters arriving on the stream
   input wire key_fifo_bank,
   // Service control
   input wire svc_start,
   input wire svc_nonapproved,
   output reg svc_accept,
   output reg svc_reject,
   output reg svc_done,
   output reg svc_error,
   // Status
   output reg stat_ready,
   output reg stat_busy,
   output reg stat_approved,
   output reg stat_nonapproved,
   output reg stat_locked,
   output reg stat_selftest_fail,
   // Datapath self-test handshake
   output reg core_kat_start,
   output reg [2:0] core_kat_index,
   input wire core_kat_done,
   input wire core_kat_pass,
   // Datapath mode and key read
   output reg core_nonapproved,
   input wire [2:0] core_key_rd_addr,
   output reg [31:0] core_key_data,
   // Datapath input words
   output reg core_in_valid,
   output reg [31:0] core_in_data,
   input wire core_in_ready,
   // Datapath result words
   input wire core_out_valid,
   input wire [31:0] core_out_data,
   input wire core_out_last,
   input wire core_err,
   output wire core_out_ready
);

   // Control state
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [2:0] kat_idx_r;
   reg [2:0] kfifo_ptr_r;
   reg mode_na_r;
   // Secret parameter banks, approved and non-approved
   reg [31:0] key_ap [0:`CSSC_KEY_WORDS-1];
   reg [31:0] key_na [0:`CSSC_KEY_WORDS-1];
   integer i;
   // FIFO wiring
   wire in_flush;
   wire out_flush;
   wire ififo_valid;
   wire [32:0] ififo_data;
   wire ififo_pop;
   wire ififo_key_pop;
   wire ififo_dat_pop;
   wire ofifo_ready;
   wire ofifo_push;
   wire in_svc;
   wire stage_free;

   assign in_svc = (state_r == `CSSC_ST_SERVICE);
   // Input queue is cleared in the init state or while the device is locked
   assign in_flush = (state_r == `CSSC_ST_LOCKED) || (state_r == `CSSC_ST_INIT);
   // Results of a failed service still queued when the error arrives are discarded
   assign out_flush = (in_svc && core_err) || (state_r == `CSSC_ST_LOCKED);
   assign stage_free = !core_in_valid || core_in_ready;
   // Key words are taken only between services
   assign ififo_key_pop = ififo_valid && ififo_data[32] && (state_r == `CSSC_ST_READY);
   // Data words feed only the datapath, only during a service
   assign ififo_dat_pop = ififo_valid && !ififo_data[32] && in_svc && stage_free;
   assign ififo_pop = ififo_key_pop || ififo_dat_pop;
   // Output queue takes only datapath results of a running service
   assign ofifo_push = core_out_valid && in_svc && !core_err;
   assign core_out_ready = ofifo_ready && in_svc;

   // Input queue, fed by DMA from the host side
   cssc_fifo #(
      .W(33)
   ) u_in_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .flush(in_flush),
      .in_valid(din_valid),
      .in_data({din_key, din_data}),
      .in_ready(din_ready),
      .out_valid(ififo_valid),
      .out_data(ififo_data),
      .out_ready(ififo_pop)
   );

   // Output queue, drained by DMA
   cssc_fifo #(
      .W(32)
   ) u_out_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .flush(out_flush),
      .in_valid(ofifo_push),
      .in_data(core_out_data),
      .in_ready(ofifo_ready),
      .out_valid(dout_valid),
      .out_data(dout_data),
      .out_ready(dout_ready)
   );

   // Next state of the security sequencer
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         `CSSC_ST_INIT:
         begin
            state_nxt = `CSSC_ST_KAT_GO;
         end
         `CSSC_ST_KAT_GO:
         begin
            state_nxt = `CSSC_ST_KAT_WAIT;
         end
         `CSSC_ST_KAT_WAIT:
         begin
            // Any failing check locks; last pass opens approved mode
            if (core_kat_done && !core_kat_pass)
            begin
               state_nxt = `CSSC_ST_LOCKED;
            end
            else if (core_kat_done && (kat_idx_r == `CSSC_NUM_KAT - 3'h1))
            begin
               state_nxt = `CSSC_ST_READY;
            end
            else if (core_kat_done)
            begin
               state_nxt = `CSSC_ST_KAT_GO;
            end
         end
         `CSSC_ST_READY:
         begin
            if (svc_start)
            begin
               state_nxt = `CSSC_ST_SERVICE;
            end
         end
         `CSSC_ST_SERVICE:
         begin
            // Last result or an error ends the service
            if (core_err || (ofifo_push && ofifo_ready && core_out_last))
            begin
               state_nxt = `CSSC_ST_READY;
            end
         end
         `CSSC_ST_LOCKED:
         begin
            // Left only through reset
            state_nxt = `CSSC_ST_LOCKED;
         end
         default:
         begin
            state_nxt = `CSSC_ST_LOCKED;
         end
      endcase
   end

   // Sequencer registers, mode and event pulses
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         // Reset restarts initialization and every check
         state_r <= `CSSC_ST_INIT;
         kat_idx_r <= 3'h0;
         mode_na_r <= 1'b0;
         svc_accept <= 1'b0;
         svc_reject <= 1'b0;
         svc_done <= 1'b0;
         svc_error <= 1'b0;
         core_kat_start <= 1'b0;
         core_kat_index <= 3'h0;
      end
      else
      begin
         state_r <= state_nxt;
         core_kat_start <= (state_r == `CSSC_ST_KAT_GO);
         core_kat_index <= kat_idx_r;
         if ((state_r == `CSSC_ST_KAT_WAIT) && core_kat_done && core_kat_pass)
         begin
            kat_idx_r <= kat_idx_r + 3'h1;
         end
         // Requests outside the ready state are refused
         svc_accept <= svc_start && (state_r == `CSSC_ST_READY);
         svc_reject <= svc_start && (state_r != `CSSC_ST_READY);
         svc_done <= in_svc && (state_nxt == `CSSC_ST_READY) && !core_err;
         svc_error <= in_svc && core_err;
         // Mode follows the class of the accepted request
         if ((state_r == `CSSC_ST_READY) && svc_start)
         begin
            mode_na_r <= svc_nonapproved;
         end
         else if (state_nxt != `CSSC_ST_SERVICE)
         begin
            mode_na_r <= 1'b0;
         end
      end
   end

   // Secret parameter storage; reset clears both banks
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         for (i = 0; i < `CSSC_KEY_WORDS; i = i + 1)
         begin
            key_ap[i] <= 32'h00000000;
            key_na[i] <= 32'h00000000;
         end
         kfifo_ptr_r <= 3'h0;
      end
      else
      begin
         // Direct write goes to the named bank only
         if (key_wr_en && !key_wr_bank)
         begin
            key_ap[key_wr_addr] <= key_wr_data;
         end
         if (key_wr_en && key_wr_bank)
         begin
            key_na[key_wr_addr] <= key_wr_data;
         end
         // Stream key words fill the chosen bank in order
         if (ififo_key_pop && !key_fifo_bank)
         begin
            key_ap[kfifo_ptr_r] <= ififo_data[31:0];
         end
         if (ififo_key_pop && key_fifo_bank)
         begin
            key_na[kfifo_ptr_r] <= ififo_data[31:0];
         end
         if (ififo_key_pop)
         begin
            kfifo_ptr_r <= kfifo_ptr_r + 3'h1;
         end
         else if (svc_start && (state_r == `CSSC_ST_READY))
         begin
            kfifo_ptr_r <= 3'h0;
         end
      end
   end

   // Datapath key read: only the bank of the running mode, zero otherwise
   always @(posedge clock)
   begin
      if (sys_rst || !in_svc)
      begin
         core_key_data <= 32'h00000000;
      end
      else if (mode_na_r)
      begin
         core_key_data <= key_na[core_key_rd_addr];
      end
      else
      begin
         core_key_data <= key_ap[core_key_rd_addr];
      end
   end

   // Input staging register toward the datapath
   always @(posedge clock)
   begin
      if (sys_rst || !in_svc)
      begin
         core_in_valid <= 1'b0;
         core_in_data <= 32'h00000000;
      end
      else if (stage_free)
      begin
         core_in_valid <= ififo_dat_pop;
         core_in_data <= ififo_dat_pop ? ififo_data[31:0] : 32'h00000000;
      end
   end

   // Status outputs; no key material ever reaches them
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         stat_ready <= 1'b0;
         stat_busy <= 1'b0;
         stat_approved <= 1'b0;
         stat_nonapproved <= 1'b0;
         stat_locked <= 1'b0;
         stat_selftest_fail <= 1'b0;
         core_nonapproved <= 1'b0;
      end
      else
      begin
         stat_ready <= (state_nxt == `CSSC_ST_READY);
         stat_busy <= (state_nxt == `CSSC_ST_SERVICE);
         stat_approved <= ((state_nxt == `CSSC_ST_READY) || (state_nxt == `CSSC_ST_SERVICE)) &&
                          !((state_nxt == `CSSC_ST_SERVICE) &&
                            (((state_r == `CSSC_ST_READY) && svc_nonapproved) ||
                             (in_svc && mode_na_r)));
         stat_nonapproved <= (state_nxt == `CSSC_ST_SERVICE) &&
                             (((state_r == `CSSC_ST_READY) && svc_nonapproved) ||
                              (in_svc && mode_na_r));
         stat_locked <= (state_nxt == `CSSC_ST_LOCKED);
         stat_selftest_fail <= (state_nxt == `CSSC_ST_LOCKED);
         core_nonapproved <= (state_nxt == `CSSC_ST_SERVICE) &&
                             (((state_r == `CSSC_ST_READY) && svc_nonapproved) ||
                              (in_svc && mode_na_r));
      end
   end

endmodule

// ===== test/cssc_core_model.sv
// Datapath model: answers checks, inverts each data word into one result.
// Assumes the controller drives the core side; fail_idx picks a failing check.
module cssc_core_model (
   input logic clock,
   input logic sys_rst,
   input logic [2:0] fail_idx,
   input logic inj_err,
   input logic core_kat_start,
   input logic [2:0] core_kat_index,
   output logic core_kat_done,
   output logic core_kat_pass,
   input logic core_in_valid,
   input logic [31:0] core_in_data,
   output logic core_in_ready,
   output logic core_out_valid,
   output logic [31:0] core_out_data,
   output logic core_out_last,
   output logic core_err,
   input logic core_out_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   assign core_err = inj_err;
   assign core_out_last = core_out_valid;
   // One word in flight at a time
   assign core_in_ready = !core_out_valid;
   // Check answers and result handshake
   always @(posedge clock)
   begin
      core_kat_done <= core_kat_start && !sys_rst;
      core_kat_pass <= core_kat_start && core_kat_index != fail_idx;
      if (sys_rst)
         core_out_valid <= 1'b0;
      else if (core_in_valid && core_in_ready)
      begin
         core_out_valid <= 1'b1;
         core_out_data <= ~core_in_data;
      end
      else if (core_out_valid && core_out_ready)
      begin
         // Released data flips so a stale word is never seen
         core_out_valid <= 1'b0;
         core_out_data <= ~core_out_data;
      end
   end
endmodule

// ===== test/cssc_top_sva.sv
// Checker for the security state controller, watching its top ports only.
// Assumes one clock and a datapath that answers each check with one done pulse.
`include "cssc_regs.vh"
module cssc_top_sva (
   input logic clock,
   input logic sys_rst,
   input logic svc_start,
   input logic svc_nonapproved,
   input logic svc_accept,
   input logic svc_reject,
   input logic svc_done,
   input logic svc_error,
   input logic stat_ready,
   input logic stat_busy,
   input logic stat_approved,
   input logic stat_nonapproved,
   input logic stat_locked,
   input logic stat_selftest_fail,
   input logic core_kat_done,
   input logic core_kat_pass,
   input logic core_nonapproved,
   input logic [31:0] core_key_data,
   input logic dout_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // Passed checks since the last reset
   logic [3:0] pass_cnt_r;
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // Counts passes, saturating
   always @(posedge clock)
   begin
      if (sys_rst)
         pass_cnt_r <= 4'h0;
      else if (core_kat_done && core_kat_pass && pass_cnt_r != 4'hf)
         pass_cnt_r <= pass_cnt_r + 4'h1;
   end
   // Request taken while idle
   sequence s_take;
      svc_start && stat_ready;
   endsequence
   // Non-approved request taken while idle
   sequence s_take_na;
      svc_start && stat_ready && svc_nonapproved;
   endsequence
   a_accept_when_ready: assert property (s_take |=> svc_accept && stat_busy && !stat_ready)
      else $error("request not accepted");
   a_reject_not_ready: assert property (svc_start && !stat_ready |=> svc_reject && !svc_accept)
      else $error("request not rejected");
   a_na_mode_switch: assert property (s_take_na |=> stat_nonapproved && core_nonapproved && !stat_approved)
      else $error("mode did not switch");
   a_done_back_approved: assert property (svc_done
      |-> stat_ready && stat_approved && !stat_nonapproved && !core_nonapproved)
      else $error("mode did not return");
   a_ready_after_tests: assert property (stat_ready || stat_approved |-> pass_cnt_r >= {1'b0, `CSSC_NUM_KAT})
      else $error("ready before all checks");
   a_fail_locks: assert property (core_kat_done && !core_kat_pass |=> stat_locked && stat_selftest_fail)
      else $error("failed check did not lock");
   a_lock_sticky: assert property (stat_locked |=> stat_locked && !svc_accept && !stat_ready)
      else $error("lock released without reset");
   a_locked_flushed: assert property (stat_locked && $past(stat_locked) |-> !dout_valid && !stat_busy)
      else $error("output while locked");
   a_key_idle_zero: assert property (!stat_busy && !$past(stat_busy) |-> core_key_data == 32'h0)
      else $error("key visible while idle");
   a_error_no_output: assert property (svc_error |=> !dout_valid && !stat_busy)
      else $error("output after error");
endmodule

bind cssc_top cssc_top_sva u_sva (.clock, .sys_rst, .svc_start, .svc_nonapproved, .svc_accept, .svc_reject,
   .svc_done, .svc_error, .stat_ready, .stat_busy, .stat_approved, .stat_nonapproved, .stat_locked,
   .stat_selftest_fail, .core_kat_done, .core_kat_pass, .core_nonapproved, .core_key_data, .dout_valid);

// ===== test/tb_crypto_security_state_control.sv
// Self-checking bench for the security state controller and a datapath model.
// Assumes the design, checker and model files are compiled ahead of it.
module tb_crypto_security_state_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic din_valid = 1'b0;
   logic [31:0] din_data = 32'h0;
   logic din_key = 1'b0;
   logic dout_ready = 1'b1;
   logic key_wr_en = 1'b0;
   logic key_wr_bank = 1'b0;
   logic [2:0] key_wr_addr = 3'h0;
   logic [31:0] key_wr_data = 32'h0;
   logic key_fifo_bank = 1'b0;
   logic svc_start = 1'b0;
   logic svc_nonapproved = 1'b0;
   logic [2:0] core_key_rd_addr = 3'h0;
   logic [2:0] fail_idx = 3'h7;
   logic inj_err = 1'b0;
   // Design outputs and core side nets
   logic din_ready, dout_valid, svc_accept, svc_reject, svc_done, svc_error, stat_ready, stat_busy;
   logic stat_approved, stat_nonapproved, stat_locked, stat_selftest_fail, core_kat_start, core_kat_done;
   logic core_kat_pass, core_nonapproved, core_in_valid, core_in_ready, core_out_valid, core_out_last;
   logic core_err, core_out_ready;
   logic [2:0] core_kat_index;
   logic [31:0] dout_data, core_key_data, core_in_data, core_out_data;
   int mismatches = 0;
   int cmp_count = 0;
   always #20 clock = ~clock;
   cssc_top dut (.clock, .sys_rst, .din_valid, .din_data, .din_key, .din_ready, .dout_valid, .dout_data,
      .dout_ready, .key_wr_en, .key_wr_bank, .key_wr_addr, .key_wr_data, .key_fifo_bank, .svc_start,
      .svc_nonapproved, .svc_accept, .svc_reject, .svc_done, .svc_error, .stat_ready, .stat_busy,
      .stat_approved, .stat_nonapproved, .stat_locked, .stat_selftest_fail, .core_kat_start,
      .core_kat_index, .core_kat_done, .core_kat_pass, .core_nonapproved, .core_key_rd_addr,
      .core_key_data, .core_in_valid, .core_in_data, .core_in_ready, .core_out_valid, .core_out_data,
      .core_out_last, .core_err, .core_out_ready);
   cssc_core_model u_core (.clock, .sys_rst, .fail_idx, .inj_err, .core_kat_start, .core_kat_index,
      .core_kat_done, .core_kat_pass, .core_in_valid, .core_in_data, .core_in_ready, .core_out_valid,
      .core_out_data, .core_out_last, .core_err, .core_out_ready);
   // Prints counts and verdict, then stops
   task automatic end_sim;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Compares one value
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         $display("Error: %s expected %h seen %h", nm, exp, seen);
         mismatches++;
      end
   endtask
   // A wait ran out
   task automatic lapse(input string nm);
      $display("Error: %s expected 1 seen 0", nm);
      mismatches++;
      end_sim;
   endtask
   // Waits for ready, lock or error
   task automatic wait_on(input int sel, input string nm);
      for (int n = 0; n < 200; n++)
      begin
         @(posedge clock);
         if ((sel == 0 ? stat_ready : sel == 1 ? stat_locked : svc_error) === 1'b1)
            return;
      end
      lapse(nm);
   endtask
   // Reset with a chosen failing check; 7 means none fails
   task automatic do_reset(input logic [2:0] f);
      fail_idx <= f;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   // Direct secret parameter write
   task automatic write_key(input logic b, input logic [2:0] a, input logic [31:0] d);
      key_wr_en <= 1'b1;
      key_wr_bank <= b;
      key_wr_addr <= a;
      key_wr_data <= d;
      @(posedge clock);
      key_wr_en <= 1'b0;
      @(posedge clock);
   endtask
   // Offers one stream word, held until an edge samples din_ready high
   task automatic push(input logic [31:0] d, input logic k);
      int n;
      din_valid <= 1'b1;
      din_data <= d;
      din_key <= k;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clock);
         if (din_ready === 1'b1)
            break;
      end
      din_valid <= 1'b0;
      if (n == 50)
         lapse("din_ready");
   endtask
   // Requests a service and judges the answer
   task automatic start_svc(input logic na, input logic ok);
      svc_start <= 1'b1;
      svc_nonapproved <= na;
      @(posedge clock);
      svc_start <= 1'b0;
      @(posedge clock);
      chk("svc_accept", svc_accept, ok);
      chk("svc_reject", svc_reject, !ok);
      chk("stat_busy", stat_busy, ok);
   endtask
   // Runs one word through the running service
   task automatic run_data(input logic [31:0] d);
      int n;
      int got;
      got = 0;
      push(d, 1'b0);
      for (n = 0; n < 50 && svc_done !== 1'b1; n++)
      begin
         @(posedge clock);
         if (dout_valid === 1'b1)
            got = 1;
         if (dout_valid === 1'b1)
            chk("dout_data", dout_data, ~d);
      end
      if (n == 50)
         lapse("svc_done");
      chk("dout_seen", got, 1);
      chk("stat_approved", stat_approved, 1'b1);
      chk("stat_nonapproved", stat_nonapproved, 1'b0);
   endtask
   task automatic test_selftest;
      start_svc(1'b0, 1'b0);
      wait_on(0, "stat_ready");
      chk("stat_approved", stat_approved, 1'b1);
      chk("stat_locked", stat_locked, 1'b0);
      $display("test_selftest done");
   endtask
   task automatic test_approved;
      push(32'h9999_aaaa, 1'b1);
      write_key(1'b0, 3'h3, 32'h1111_2222);
      write_key(1'b1, 3'h3, 32'h3333_4444);
      core_key_rd_addr <= 3'h3;
      start_svc(1'b0, 1'b1);
      chk("core_nonapproved", core_nonapproved, 1'b0);
      @(posedge clock);
      chk("core_key_data", core_key_data, 32'h1111_2222);
      core_key_rd_addr <= 3'h0;
      repeat (2) @(posedge clock);
      chk("core_key_data", core_key_data, 32'h9999_aaaa);
      run_data(32'h0123_abcd);
      $display("test_approved done");
   endtask
   task automatic test_nonapproved;
      key_fifo_bank <= 1'b1;
      push(32'h5555_6666, 1'b1);
      repeat (3) @(posedge clock);
      core_key_rd_addr <= 3'h0;
      start_svc(1'b1, 1'b1);
      chk("stat_nonapproved", stat_nonapproved, 1'b1);
      chk("core_nonapproved", core_nonapproved, 1'b1);
      @(posedge clock);
      chk("core_key_data", core_key_data, 32'h5555_6666);
      run_data(32'hfeed_0042);
      $display("test_nonapproved done");
   endtask
   task automatic test_error;
      core_key_rd_addr <= 3'h3;
      start_svc(1'b0, 1'b1);
      inj_err <= 1'b1;
      @(posedge clock);
      inj_err <= 1'b0;
      wait_on(2, "svc_error");
      repeat (2) @(posedge clock);
      chk("dout_valid", dout_valid, 1'b0);
      chk("core_key_data", core_key_data, 32'h0);
      chk("stat_ready", stat_ready, 1'b1);
      $display("test_error done");
   endtask
   task automatic test_lock;
      do_reset(3'h2);
      wait_on(1, "stat_locked");
      chk("stat_selftest_fail", stat_selftest_fail, 1'b1);
      start_svc(1'b0, 1'b0);
      do_reset(3'h7);
      wait_on(0, "stat_ready");
      core_key_rd_addr <= 3'h3;
      start_svc(1'b1, 1'b1);
      @(posedge clock);
      chk("core_key_data", core_key_data, 32'h0);
      run_data(32'h7777_0000);
      $display("test_lock done");
   endtask
   // Main sequence
   initial
   begin
      do_reset(3'h7);
      test_selftest;
      test_approved;
      test_nonapproved;
      test_error;
      test_lock;
      end_sim;
   end
endmodule
